// ### tb/aer_units_model.sv
`timescale 1ns/1ps
// stands in for the alu status and channel control owners
module aer_units_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       ptr_wr_i,
  input  wire logic [1:0] ptr_i,
  input  wire logic       fcnt_wr_i,
  input  wire logic [4:0] fcnt_i,
  input  wire logic       cnt_wr_i,
  input  wire logic [7:0] cnt_i,
  output logic      [11:0] alu_status_o,
  output logic      [7:0]  count_left_o
);
  // upper status bits start set so a stray field write shows up
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      alu_status_o <= 12'hf80;
    end else begin
      if (ptr_wr_i) begin
        alu_status_o[6:5] <= ptr_i;
      end
      if (fcnt_wr_i) begin
        alu_status_o[4:0] <= fcnt_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      count_left_o <= 8'h00;
    end else if (cnt_wr_i) begin
      count_left_o <= cnt_i;
    end
  end
endmodule // aer_units_model

// ### tb/test_arith_env_status_regs.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module test_arith_env_status_regs;
  logic        clk = 1'b0, rst_b = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic        rd_valid, ptr_wr, fcnt_wr, cnt_wr, fast, fp_trap, rng_trap;
  logic [1:0]  ptr, rnd;
  logic [4:0]  fcnt;
  logic [7:0]  cnt, cnt_live;
  logic [11:0] alu_st;
  logic        fp_v = 1'b0, int_v = 1'b0, idiv = 1'b0, imul = 1'b0;
  logic        iovf = 1'b0, idz = 1'b0;
  logic [5:0]  fp_exc = 6'h00;
  int          bad_count = 0, comparisons = 0;
  logic [8:0]  fe;
  logic [5:0]  ex;
  logic        tr;
  logic [13:0] st;
  // fenv, exc, expected trap, expected status
  logic [29:0] rows [11] = '{
    {9'h000, 6'h21, 1'b1, 14'h2100}, {9'h060, 6'h21, 1'b1, 14'h2120},
    {9'h0bf, 6'h3f, 1'b0, 14'h003f}, {9'h1df, 6'h20, 1'b1, 14'h2000},
    {9'h11e, 6'h1e, 1'b0, 14'h001e}, {9'h00f, 6'h30, 1'b1, 14'h3000},
    {9'h03b, 6'h04, 1'b1, 14'h0400}, {9'h037, 6'h0c, 1'b1, 14'h0c04},
    {9'h02f, 6'h12, 1'b1, 14'h1202}, {9'h03d, 6'h02, 1'b1, 14'h0200},
    {9'h03e, 6'h01, 1'b1, 14'h0100}};

  always #5 clk = ~clk;

  aer_arith_env_regs aer_arith_env_regs_inst (
    .sys_clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .spr_wr_i(wr),
    .spr_rd_i(rd), .spr_addr_i(addr), .spr_wdata_i(wdata),
    .spr_rdata_o(rdata), .spr_rd_valid_o(rd_valid),
    .alu_byte_ptr_i(alu_st[6:5]), .alu_funnel_cnt_i(alu_st[4:0]),
    .chan_count_left_i(cnt_live), .byte_ptr_wr_o(ptr_wr),
    .byte_ptr_o(ptr), .funnel_cnt_wr_o(fcnt_wr), .funnel_cnt_o(fcnt),
    .count_left_wr_o(cnt_wr), .count_left_o(cnt), .fast_float_o(fast),
    .fp_round_mode_o(rnd), .fp_op_valid_i(fp_v), .fp_exc_i(fp_exc),
    .fp_trap_o(fp_trap), .int_op_valid_i(int_v), .int_div_i(idiv),
    .int_mul_i(imul), .int_overflow_i(iovf), .int_div_zero_i(idz),
    .range_trap_o(rng_trap));

  aer_units_model aer_units_model_inst (
    .sys_clk_i(clk), .rst_b_i(rst_b), .ptr_wr_i(ptr_wr), .ptr_i(ptr),
    .fcnt_wr_i(fcnt_wr), .fcnt_i(fcnt), .cnt_wr_i(cnt_wr), .cnt_i(cnt),
    .alu_status_o(alu_st), .count_left_o(cnt_live));

  // each move lets an idle edge pass first, so a strobe lowered by the
  // previous move is never raised again in the same time step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); #1 addr = a; wdata = d; wr = 1'b1;
    @(posedge clk); #1 wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk); #1 addr = a; rd = 1'b1;
    @(posedge clk); #1 rd = 1'b0;
    `CHK(rd_valid, 1'b1)
    `CHK(rdata, e)
  endtask

  task automatic fp_op(input logic [5:0] x, input logic t);
    @(posedge clk); #1 fp_v = 1'b1; fp_exc = x;
    @(posedge clk); #1 fp_v = 1'b0;
    `CHK(fp_trap, t)
  endtask

  task automatic int_op(input logic dv, ml, ov, dz, t);
    @(posedge clk); #1 int_v = 1'b1; idiv = dv; imul = ml; iovf = ov;
    idz = dz;
    @(posedge clk); #1 int_v = 1'b0;
    `CHK(rng_trap, t)
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
    `CHK(fp_trap, 1'b0)
    rd_chk(aer_pkg::ADDR_FLOAT_ENV, 32'h0000_0000);
    rd_chk(aer_pkg::ADDR_INT_ENV, 32'h0000_0000);
    rd_chk(aer_pkg::ADDR_FLOAT_STAT, 32'h0000_0000);
    foreach (rows[i]) begin
      {fe, ex, tr, st} = rows[i];
      wr_reg(aer_pkg::ADDR_FLOAT_STAT, 32'h0000_0000);
      wr_reg(aer_pkg::ADDR_FLOAT_ENV, {23'h00_0000, fe});
      `CHK(fast, fe[8])
      `CHK(rnd, fe[7:6])
      fp_op(ex, tr);
      rd_chk(aer_pkg::ADDR_FLOAT_STAT, {18'h0_0000, st});
    end
    // causes persist over masked ops, sticky survives later traps
    wr_reg(aer_pkg::ADDR_FLOAT_STAT, 32'h0000_0000);
    wr_reg(aer_pkg::ADDR_FLOAT_ENV, 32'h0000_003e);
    fp_op(6'h03, 1'b1);
    rd_chk(aer_pkg::ADDR_FLOAT_STAT, 32'h0000_0302);
    wr_reg(aer_pkg::ADDR_FLOAT_ENV, 32'h0000_003f);
    fp_op(6'h10, 1'b0);
    rd_chk(aer_pkg::ADDR_FLOAT_STAT, 32'h0000_0312);
    wr_reg(aer_pkg::ADDR_FLOAT_ENV, 32'h0000_0000);
    fp_op(6'h04, 1'b1);
    rd_chk(aer_pkg::ADDR_FLOAT_STAT, 32'h0000_0412);
    wr_reg(aer_pkg::ADDR_FLOAT_STAT, 32'h0000_0000);
    rd_chk(aer_pkg::ADDR_FLOAT_STAT, 32'h0000_0000);
    // aliases
    wr_reg(aer_pkg::ADDR_BYTE_PTR, 32'hffff_fffe);
    `CHK(ptr_wr, 1'b1)
    `CHK(ptr, 2'h2)
    @(posedge clk); #1 `CHK(ptr_wr, 1'b0)
    rd_chk(aer_pkg::ADDR_BYTE_PTR, 32'h0000_0002);
    wr_reg(aer_pkg::ADDR_FUNNEL_CNT, 32'hffff_ffed);
    `CHK(fcnt_wr, 1'b1)
    `CHK(fcnt, 5'h0d)
    repeat (2) @(posedge clk);
    #1 `CHK(alu_st, 12'hfcd)
    rd_chk(aer_pkg::ADDR_FUNNEL_CNT, 32'h0000_000d);
    wr_reg(aer_pkg::ADDR_COUNT_LEFT, 32'h1234_56a5);
    `CHK(cnt_wr, 1'b1)
    `CHK(cnt, 8'ha5)
    repeat (2) @(posedge clk);
    #1 rd_chk(aer_pkg::ADDR_COUNT_LEFT, 32'h0000_00a5);
    // integer traps with no mask, the multiply mask, and both masks set
    wr_reg(aer_pkg::ADDR_INT_ENV, 32'h0000_0000);
    int_op(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    int_op(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    int_op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    wr_reg(aer_pkg::ADDR_INT_ENV, 32'h0000_0001);
    int_op(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    int_op(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    wr_reg(aer_pkg::ADDR_INT_ENV, 32'hffff_ffff);
    rd_chk(aer_pkg::ADDR_INT_ENV, 32'h0000_0003);
    int_op(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    int_op(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    // reserved bits and an unmapped number
    wr_reg(aer_pkg::ADDR_FLOAT_ENV, 32'hffff_ffff);
    rd_chk(aer_pkg::ADDR_FLOAT_ENV, 32'h0000_01ff);
    wr_reg(aer_pkg::ADDR_FLOAT_STAT, 32'hffff_ffff);
    rd_chk(aer_pkg::ADDR_FLOAT_STAT, 32'h0000_3f3f);
    wr_reg(8'h55, 32'hffff_ffff);
    rd_chk(8'h55, 32'h0000_0000);
    // frozen clock enable swallows an unmasked op
    wr_reg(aer_pkg::ADDR_FLOAT_ENV, 32'h0000_0000);
    ce = 1'b0;
    fp_op(6'h01, 1'b0);
    ce = 1'b1;
    rd_chk(aer_pkg::ADDR_FLOAT_STAT, 32'h0000_3f3f);
    // second reset in mid-run
    rst_b = 1'b0;
    @(posedge clk); #1 rst_b = 1'b1;
    rd_chk(aer_pkg::ADDR_FLOAT_STAT, 32'h0000_0000);
    rd_chk(aer_pkg::ADDR_INT_ENV, 32'h0000_0000);
    close_out();
  end
endmodule // test_arith_env_status_regs

// ### verilog/aer_arith_env_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - byte pointer alias writes only pointer field
// - funnel count alias writes only count field
// - count-remaining alias writes only channel count
// - fast float bit enables relaxed fast mode
// - rounding field selects default rounding mode
// - unmasked divide by zero raises fp trap
// - unmasked inexact result raises fp trap
// - unmasked underflow raises fp trap
// - unmasked overflow raises fp trap
// - unmasked reserved operand raises fp trap
// - unmasked invalid operation raises fp trap
// - unmasked divide overflow raises range trap
// - integer divide by zero always traps
// - unmasked multiply overflow raises range trap
// - cause bits change only on fp trap or status write
// - cause set regardless of its own mask
// - inapplicable cause bits cleared on trap
// - sticky set when masked, cleared by write
// - masked sticky set even when others trap
// - cause bit positions thirteen down to eight
// - sticky bit positions five down to zero
// - pointer and funnel aliases steer to alu status fields, count-remaining to channel count
module aer_arith_env_regs #(
  parameter int DATA_W = 32
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_b_i,
  input  wire logic                      ce_i,
  // special register moves
  input  wire logic                      spr_wr_i,
  input  wire logic                      spr_rd_i,
  input  wire logic [7:0]                spr_addr_i,
  input  wire logic [DATA_W-1:0]         spr_wdata_i,
  output logic      [DATA_W-1:0]         spr_rdata_o,
  output logic                           spr_rd_valid_o,
  // live fields held by the alu status and channel control words
  input  wire logic [aer_pkg::BYTE_PTR_W-1:0]   alu_byte_ptr_i,
  input  wire logic [aer_pkg::FUNNEL_CNT_W-1:0] alu_funnel_cnt_i,
  input  wire logic [aer_pkg::COUNT_LEFT_W-1:0] chan_count_left_i,
  output logic                           byte_ptr_wr_o,
  output logic [aer_pkg::BYTE_PTR_W-1:0] byte_ptr_o,
  output logic                           funnel_cnt_wr_o,
  output logic [aer_pkg::FUNNEL_CNT_W-1:0] funnel_cnt_o,
  output logic                           count_left_wr_o,
  output logic [aer_pkg::COUNT_LEFT_W-1:0] count_left_o,
  // floating-point unit controls and reports
  output logic                           fast_float_o,
  output logic [aer_pkg::FENV_RND_W-1:0] fp_round_mode_o,
  input  wire logic                      fp_op_valid_i,
  input  wire logic [aer_pkg::EXC_W-1:0] fp_exc_i,
  output logic                           fp_trap_o,
  // integer unit reports
  input  wire logic                      int_op_valid_i,
  input  wire logic                      int_div_i,
  input  wire logic                      int_mul_i,
  input  wire logic                      int_overflow_i,
  input  wire logic                      int_div_zero_i,
  output logic                           range_trap_o
);

  logic [aer_pkg::FENV_W-1:0] fenv_r;
  logic [aer_pkg::IENV_W-1:0] ienv_r;
  logic [aer_pkg::EXC_W-1:0]  trap_flag_r;
  logic [aer_pkg::EXC_W-1:0]  sticky_r;
  logic [aer_pkg::EXC_W-1:0]  fp_mask;
  logic                       fp_trap_req;
  logic [aer_pkg::EXC_W-1:0]  fp_cause;
  logic [aer_pkg::EXC_W-1:0]  fp_sticky_set;
  logic                       int_trap_req;
  logic                       wr_bp;
  logic                       wr_fc;
  logic                       wr_cr;
  logic                       wr_fenv;
  logic                       wr_ienv;
  logic                       wr_fstat;
  logic [DATA_W-1:0]          rd_mux;

  assign wr_bp    = spr_wr_i && (spr_addr_i == aer_pkg::ADDR_BYTE_PTR);
  assign wr_fc    = spr_wr_i && (spr_addr_i == aer_pkg::ADDR_FUNNEL_CNT);
  assign wr_cr    = spr_wr_i && (spr_addr_i == aer_pkg::ADDR_COUNT_LEFT);
  assign wr_fenv  = spr_wr_i && (spr_addr_i == aer_pkg::ADDR_FLOAT_ENV);
  assign wr_ienv  = spr_wr_i && (spr_addr_i == aer_pkg::ADDR_INT_ENV);
  assign wr_fstat = spr_wr_i && (spr_addr_i == aer_pkg::ADDR_FLOAT_STAT);

  assign fp_mask = fenv_r[aer_pkg::FENV_MASK_LSB +: aer_pkg::EXC_W];

  aer_exc_eval #(
    .W (aer_pkg::EXC_W)
  ) u_exc_eval (
    .valid_i      (fp_op_valid_i),
    .exc_i        (fp_exc_i),
    .mask_i       (fp_mask),
    .trap_o       (fp_trap_req),
    .cause_o      (fp_cause),
    .sticky_set_o (fp_sticky_set)
  );

  // zero divisor traps whatever the mask says
  assign int_trap_req = int_op_valid_i && (
      (int_div_i && int_div_zero_i) ||
      (int_div_i && int_overflow_i &&
       !ienv_r[aer_pkg::IENV_DIV_BIT]) ||
      (int_mul_i && int_overflow_i &&
       !ienv_r[aer_pkg::IENV_MUL_BIT]));

  // alias writes: only the addressed field is sent to its owner
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      byte_ptr_wr_o   <= 1'b0;
      funnel_cnt_wr_o <= 1'b0;
      count_left_wr_o <= 1'b0;
    end else if (ce_i) begin
      byte_ptr_wr_o   <= wr_bp;
      funnel_cnt_wr_o <= wr_fc;
      count_left_wr_o <= wr_cr;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      byte_ptr_o   <= '0;
      funnel_cnt_o <= '0;
      count_left_o <= '0;
    end else if (ce_i) begin
      if (wr_bp) begin
        byte_ptr_o <= spr_wdata_i[aer_pkg::BYTE_PTR_W-1:0];
      end
      if (wr_fc) begin
        funnel_cnt_o <= spr_wdata_i[aer_pkg::FUNNEL_CNT_W-1:0];
      end
      if (wr_cr) begin
        count_left_o <= spr_wdata_i[aer_pkg::COUNT_LEFT_W-1:0];
      end
    end
  end

  // environment registers; bits above the fields are dropped
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fenv_r <= aer_pkg::FENV_RST;
    end else if (ce_i && wr_fenv) begin
      fenv_r <= spr_wdata_i[aer_pkg::FENV_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ienv_r <= aer_pkg::IENV_RST;
    end else if (ce_i && wr_ienv) begin
      ienv_r <= spr_wdata_i[aer_pkg::IENV_W-1:0];
    end
  end

  assign fast_float_o    = fenv_r[aer_pkg::FENV_FAST_BIT];
  assign fp_round_mode_o =
      fenv_r[aer_pkg::FENV_RND_LSB +: aer_pkg::FENV_RND_W];

  // a trap in the same cycle as a software write wins the cause bits
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      trap_flag_r <= aer_pkg::FSTAT_RST;
    end else if (ce_i) begin
      if (fp_trap_req) begin
        trap_flag_r <= fp_cause;
      end else if (wr_fstat) begin
        trap_flag_r <=
            spr_wdata_i[aer_pkg::FSTAT_TRAP_LSB +: aer_pkg::EXC_W];
      end
    end
  end

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sticky_r <= aer_pkg::FSTAT_RST;
    end else if (ce_i) begin
      if (wr_fstat) begin
        sticky_r <= spr_wdata_i[aer_pkg::FSTAT_STICKY_LSB +:
                                aer_pkg::EXC_W] | fp_sticky_set;
      end else begin
        sticky_r <= sticky_r | fp_sticky_set;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fp_trap_o    <= 1'b0;
      range_trap_o <= 1'b0;
    end else if (ce_i) begin
      fp_trap_o    <= fp_trap_req;
      range_trap_o <= int_trap_req;
    end
  end

  // read side; aliases show the live owner fields, not a stale copy
  always_comb begin
    rd_mux = '0;
    case (spr_addr_i)
      aer_pkg::ADDR_BYTE_PTR: begin
        rd_mux[aer_pkg::BYTE_PTR_W-1:0] = alu_byte_ptr_i;
      end
      aer_pkg::ADDR_FUNNEL_CNT: begin
        rd_mux[aer_pkg::FUNNEL_CNT_W-1:0] = alu_funnel_cnt_i;
      end
      aer_pkg::ADDR_COUNT_LEFT: begin
        rd_mux[aer_pkg::COUNT_LEFT_W-1:0] = chan_count_left_i;
      end
      aer_pkg::ADDR_FLOAT_ENV: begin
        rd_mux[aer_pkg::FENV_W-1:0] = fenv_r;
      end
      aer_pkg::ADDR_INT_ENV: begin
        rd_mux[aer_pkg::IENV_W-1:0] = ienv_r;
      end
      aer_pkg::ADDR_FLOAT_STAT: begin
        rd_mux[aer_pkg::FSTAT_TRAP_LSB +: aer_pkg::EXC_W] = trap_flag_r;
        rd_mux[aer_pkg::FSTAT_STICKY_LSB +: aer_pkg::EXC_W] = sticky_r;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      spr_rdata_o    <= '0;
      spr_rd_valid_o <= 1'b0;
    end else if (ce_i) begin
      spr_rd_valid_o <= spr_rd_i;
      if (spr_rd_i) begin
        spr_rdata_o <= rd_mux;
      end
    end
  end

  // checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_fp_trap_req;
    ce_i && fp_op_valid_i && (|(fp_exc_i & ~fp_mask));
  endsequence

  sequence s_fp_quiet;
    ce_i && !(fp_op_valid_i && (|(fp_exc_i & ~fp_mask)));
  endsequence

  sequence s_status_write;
    ce_i && wr_fstat;
  endsequence

  property p_bp_alias;
    (ce_i && wr_bp) |=>
      byte_ptr_wr_o && (byte_ptr_o == $past(spr_wdata_i[1:0]));
  endproperty
  a_bp_alias: assert property (p_bp_alias)
    else $error("byte pointer alias write not forwarded");

  property p_fc_alias;
    (ce_i && wr_fc) |=>
      funnel_cnt_wr_o && (funnel_cnt_o == $past(spr_wdata_i[4:0]));
  endproperty
  a_fc_alias: assert property (p_fc_alias)
    else $error("funnel count alias write not forwarded");

  property p_cr_alias;
    (ce_i && wr_cr) |=>
      count_left_wr_o && (count_left_o == $past(spr_wdata_i[7:0]));
  endproperty
  a_cr_alias: assert property (p_cr_alias)
    else $error("count remaining alias write not forwarded");

  property p_fenv_ctrl;
    (ce_i && wr_fenv) |=>
      (fast_float_o == $past(spr_wdata_i[8])) &&
      (fp_round_mode_o == $past(spr_wdata_i[7:6]));
  endproperty
  a_fenv_ctrl: assert property (p_fenv_ctrl)
    else $error("fast mode or rounding not taken from write");

  property p_fp_trap;
    s_fp_trap_req |=> fp_trap_o;
  endproperty
  a_fp_trap: assert property (p_fp_trap)
    else $error("unmasked fp exception did not trap");

  property p_fp_no_trap;
    s_fp_quiet |=> !fp_trap_o;
  endproperty
  a_fp_no_trap: assert property (p_fp_no_trap)
    else $error("fp trap without an unmasked exception");

  property p_int_divzero;
    (ce_i && int_op_valid_i && int_div_i && int_div_zero_i) |=> range_trap_o;
  endproperty
  a_int_divzero: assert property (p_int_divzero)
    else $error("integer divide by zero did not trap");

  property p_int_masked;
    (ce_i && int_op_valid_i && !int_div_zero_i && int_overflow_i &&
     ((int_div_i && ienv_r[1]) || (int_mul_i && ienv_r[0])) &&
     !(int_div_i && !ienv_r[1]) && !(int_mul_i && !ienv_r[0]))
      |=> !range_trap_o;
  endproperty
  a_int_masked: assert property (p_int_masked)
    else $error("masked integer overflow trapped");

  property p_cause_on_trap;
    s_fp_trap_req |=> (trap_flag_r == $past(fp_exc_i));
  endproperty
  a_cause_on_trap: assert property (p_cause_on_trap)
    else $error("cause bits do not match trapping operation");

  property p_cause_hold;
    (s_fp_quiet and !wr_fstat) |=> $stable(trap_flag_r);
  endproperty
  a_cause_hold: assert property (p_cause_hold)
    else $error("cause bits changed without a trap");

  property p_sticky_update;
    (ce_i && !wr_fstat) |=>
      (sticky_r == ($past(sticky_r) |
                    ($past(fp_op_valid_i) ? $past(fp_exc_i & fp_mask)
                                          : 6'h00)));
  endproperty
  a_sticky_update: assert property (p_sticky_update)
    else $error("sticky bits wrong after operation");

  property p_sticky_clear;
    s_status_write |=>
      (sticky_r == ($past(spr_wdata_i[5:0]) | $past(fp_sticky_set)));
  endproperty
  a_sticky_clear: assert property (p_sticky_clear)
    else $error("sticky bits not rewritten by status write");

  property p_reserved_zero;
    (ce_i && spr_rd_i && (spr_addr_i == aer_pkg::ADDR_FLOAT_STAT)) |=>
      (spr_rdata_o[31:14] == 18'h0_0000) && (spr_rdata_o[7:6] == 2'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved status bits read nonzero");

endmodule // aer_arith_env_regs

// ### verilog/aer_exc_eval.sv
`timescale 1ns/1ps
// splits one operation's exception set into trap, causes and sticky sets
module aer_exc_eval #(
  parameter int W = 6
) (
  input  wire logic         valid_i,
  input  wire logic [W-1:0] exc_i,
  input  wire logic [W-1:0] mask_i,
  output logic              trap_o,
  output logic [W-1:0]      cause_o,
  output logic [W-1:0]      sticky_set_o
);

  // any unmasked condition traps; causes report all conditions
  assign trap_o       = valid_i && (|(exc_i & ~mask_i));
  assign cause_o      = exc_i;
  // masked conditions go sticky even when a sibling traps
  assign sticky_set_o = valid_i ? (exc_i & mask_i) : '0;

endmodule // aer_exc_eval

// ### verilog/aer_pkg.sv
package aer_pkg;

  // special register numbers
  localparam logic [7:0] ADDR_BYTE_PTR   = 8'h85;
  localparam logic [7:0] ADDR_FUNNEL_CNT = 8'h86;
  localparam logic [7:0] ADDR_COUNT_LEFT = 8'h87;
  localparam logic [7:0] ADDR_FLOAT_ENV  = 8'ha0;
  localparam logic [7:0] ADDR_INT_ENV    = 8'ha1;
  localparam logic [7:0] ADDR_FLOAT_STAT = 8'ha2;

  // aliased field widths
  localparam int BYTE_PTR_W   = 2;
  localparam int FUNNEL_CNT_W = 5;
  localparam int COUNT_LEFT_W = 8;

  // positions of the aliased fields inside the alu status word
  localparam int ALU_BYTE_PTR_LSB   = 5;
  localparam int ALU_FUNNEL_CNT_LSB = 0;

  // floating-point exception index, shared by masks, causes and sticky bits
  localparam int EXC_W        = 6;
  localparam int EXC_INVALID  = 0;
  localparam int EXC_RES_OPND = 1;
  localparam int EXC_OVERFLOW = 2;
  localparam int EXC_UNDERFLW = 3;
  localparam int EXC_INEXACT  = 4;
  localparam int EXC_DIVZERO  = 5;

  // float environment layout
  localparam int FENV_W        = 9;
  localparam int FENV_MASK_LSB = 0;
  localparam int FENV_RND_LSB  = 6;
  localparam int FENV_RND_W    = 2;
  localparam int FENV_FAST_BIT = 8;
  localparam logic [FENV_W-1:0] FENV_RST = 9'h000;

  // integer environment layout
  localparam int IENV_W       = 2;
  localparam int IENV_MUL_BIT = 0;
  localparam int IENV_DIV_BIT = 1;
  localparam logic [IENV_W-1:0] IENV_RST = 2'h0;

  // float status layout
  localparam int FSTAT_STICKY_LSB = 0;
  localparam int FSTAT_TRAP_LSB   = 8;
  localparam logic [EXC_W-1:0] FSTAT_RST = 6'h00;

  typedef enum logic [1:0] {
    AER_RND_NEAREST = 2'h0,
    AER_RND_MINUS   = 2'h1,
    AER_RND_PLUS    = 2'h2,
    AER_RND_ZERO    = 2'h3
  } aer_round_e;

endpackage
